// ### logic/sse_exec.sv
// subtract and sleep execution block with axi4-lite register slave
//
// Added by the designer: the address map and the AXI4-Lite slave port.
`include "sse_params.svh"
// How it works
// - sleep clears watchdog counter and prescaler
// - sleep sets expiry, clears low-power flag
// - sleep halts oscillator, enters sleep state
// - literal subtract: literal minus acc into acc
// - file subtract: file minus acc, flags
// - destination bit picks acc or file
// - carry set when no borrow
module sse_exec (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output sse_pkg::sse_ev_t irq_stat,
   output logic irq,
   output logic osc_en,
   output logic file_we,
   output logic [6:0] file_addr,
   output logic [7:0] file_wdata
);
   import sse_pkg::*;

   logic aw_held, w_held;
   logic [7:0] wa;
   logic [31:0] wd;
   logic [3:0] ws;
   logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
   logic next_awready, next_wready, next_arready;
   logic [7:0] next_wa;
   logic [31:0] next_wd, next_rdata;
   logic [3:0] next_ws;
   logic [1:0] next_bresp, next_rresp;
   logic wr_do;
   logic [31:0] wmask, merged;

   logic pend, next_pend;
   logic [13:0] pend_op, next_pend_op;
   logic [7:0] acc, next_acc, fdata, next_fdata;
   logic carry, next_carry, nibf, next_nibf, zf, next_zf;
   logic expiry_flag, next_expiry_flag;
   logic low_power_entry_flag, next_low_power_entry_flag;
   logic sleeping, next_sleeping, next_osc_en;
   logic [7:0] presc, next_presc, watchdog_counter, next_watchdog_counter;
   logic next_file_we, next_irq;
   logic [6:0] next_file_addr;
   logic [7:0] next_file_wdata;
   sse_ev_t ev, next_irq_stat, irq_en, next_irq_en;
   sse_kind_t kind;
   logic [7:0] sub_a, diff;
   logic [8:0] wide;
   logic [4:0] nib;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == `SSE_A_OPC) || (a == `SSE_A_FDATA) || (a == `SSE_A_ACC)
         || (a == `SSE_A_STAT) || (a == `SSE_A_WDOG) || (a == `SSE_A_IRQ_STAT)
         || (a == `SSE_A_IRQ_CLR) || (a == `SSE_A_IRQ_EN) || (a == `SSE_A_WAKE);
   endfunction : mapped

   function automatic logic [31:0] rd(input logic [7:0] a);
      rd = 32'h0000_0000;
      if (a == `SSE_A_OPC) begin
         rd[13:0] = pend_op;
      end else if (a == `SSE_A_FDATA) begin
         rd[7:0] = fdata;
      end else if (a == `SSE_A_ACC) begin
         rd[7:0] = acc;
      end else if (a == `SSE_A_STAT) begin
         rd[`SSE_B_CARRY] = carry;
         rd[`SSE_B_NIB] = nibf;
         rd[`SSE_B_ZERO] = zf;
         rd[`SSE_B_LPE] = low_power_entry_flag;
         rd[`SSE_B_EXP] = expiry_flag;
         rd[`SSE_B_SLP] = sleeping;
      end else if (a == `SSE_A_WDOG) begin
         rd[15:0] = {presc, watchdog_counter};
      end else if (a == `SSE_A_IRQ_STAT) begin
         rd[2:0] = irq_stat;
      end else if (a == `SSE_A_IRQ_EN) begin
         rd[2:0] = irq_en;
      end
   endfunction : rd

   for (genvar i = 0; i < 4; i++) begin : g_lane
      assign wmask[8*i+:8] = ws[i] ? 8'hFF : 8'h00;
   end
   // always_comb so the merge follows register changes read inside rd
   always_comb begin
      merged = (rd(wa) & ~wmask) | (wd & wmask);
   end
   assign wr_do = aw_held && w_held && !s_axi_bvalid;

   // address and data may land in either order; both held before the write acts
   always_comb begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_wa = wa;
      next_wd = wd;
      next_ws = ws;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      next_rvalid = s_axi_rvalid;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_wa = s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_wd = s_axi_wdata;
         next_ws = s_axi_wstrb;
      end
      if (wr_do) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = mapped(wa) ? `SSE_RESP_OK : `SSE_RESP_ERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rdata = rd(s_axi_araddr[7:0]);
         next_rresp = mapped(s_axi_araddr[7:0]) ? `SSE_RESP_OK : `SSE_RESP_ERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      next_awready = !next_aw_held && !next_bvalid;
      next_wready = !next_w_held && !next_bvalid;
      next_arready = !next_rvalid;
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         wa <= 8'h00;
         wd <= 32'h0000_0000;
         ws <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SSE_RESP_OK;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `SSE_RESP_OK;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_arready <= 1'b0;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         wa <= next_wa;
         wd <= next_wd;
         ws <= next_ws;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         s_axi_arready <= next_arready;
      end
   end

   always_comb begin
      if (!pend) begin
         kind = K_NONE;
      end else if (pend_op == `SSE_OP_SLEEP) begin
         kind = K_SLEEP;
      end else if (pend_op[13:9] == `SSE_OP_LIT) begin
         kind = K_LIT;
      end else if (pend_op[13:8] == `SSE_OP_FILE) begin
         kind = K_FILE;
      end else begin
         kind = K_BAD;
      end
   end

   // borrow is carried as a complement add, so carry high means no borrow
   assign sub_a = (kind == K_LIT) ? pend_op[7:0] : fdata;
   assign wide = {1'b0, sub_a} + {1'b0, ~acc} + 9'h001;
   assign nib = {1'b0, sub_a[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
   assign diff = wide[7:0];

   always_comb begin
      next_pend = 1'b0;
      next_pend_op = pend_op;
      next_acc = acc;
      next_fdata = fdata;
      next_carry = carry;
      next_nibf = nibf;
      next_zf = zf;
      next_expiry_flag = expiry_flag;
      next_low_power_entry_flag = low_power_entry_flag;
      next_sleeping = sleeping;
      next_osc_en = osc_en;
      next_presc = presc + 8'h01;
      next_watchdog_counter = watchdog_counter;
      next_file_we = 1'b0;
      next_file_addr = file_addr;
      next_file_wdata = file_wdata;
      next_irq_en = irq_en;
      ev = 3'h0;
      if (presc == `SSE_PRESC_MAX) begin
         next_watchdog_counter = watchdog_counter + 8'h01;
      end
      case (kind)
         K_SLEEP: begin
            next_presc = `SSE_WDOG_CLR;
            next_watchdog_counter = `SSE_WDOG_CLR;
            next_expiry_flag = 1'b1;
            next_low_power_entry_flag = 1'b0;
            next_sleeping = 1'b1;
            next_osc_en = 1'b0;
            ev[`SSE_EV_SLEEP] = 1'b1;
         end
         K_LIT, K_FILE: begin
            next_carry = wide[8];
            next_nibf = nib[4];
            next_zf = (diff == 8'h00);
            ev[`SSE_EV_DONE] = 1'b1;
            if (kind == K_FILE && pend_op[7]) begin
               next_file_we = 1'b1;
               next_file_addr = pend_op[6:0];
               next_file_wdata = diff;
               next_fdata = diff;
            end else begin
               next_acc = diff;
            end
         end
         K_BAD: begin
            ev[`SSE_EV_BAD] = 1'b1;
         end
         default: begin
         end
      endcase
      // opcodes written while asleep are dropped
      if (wr_do && wa == `SSE_A_OPC && !sleeping) begin
         next_pend = 1'b1;
         next_pend_op = merged[13:0];
      end else if (wr_do && wa == `SSE_A_ACC) begin
         next_acc = merged[7:0];
      end else if (wr_do && wa == `SSE_A_FDATA) begin
         next_fdata = merged[7:0];
      end else if (wr_do && wa == `SSE_A_IRQ_EN) begin
         next_irq_en = merged[2:0];
      end else if (wr_do && wa == `SSE_A_WAKE && wd[0] && ws[0]) begin
         next_sleeping = 1'b0;
         next_osc_en = 1'b1;
      end
      // a new event beats a clear in the same cycle
      next_irq_stat = irq_stat | ev;
      if (wr_do && wa == `SSE_A_IRQ_CLR && ws[0]) begin
         next_irq_stat = (irq_stat & ~wd[2:0]) | ev;
      end
      next_irq = |(next_irq_stat & next_irq_en);
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pend <= 1'b0;
         pend_op <= 14'h0000;
         acc <= 8'h00;
         fdata <= 8'h00;
         carry <= 1'b0;
         nibf <= 1'b0;
         zf <= 1'b0;
         expiry_flag <= `SSE_RST_EXP;
         low_power_entry_flag <= `SSE_RST_LPE;
         sleeping <= 1'b0;
         osc_en <= 1'b1;
         presc <= `SSE_WDOG_CLR;
         watchdog_counter <= `SSE_WDOG_CLR;
         file_we <= 1'b0;
         file_addr <= 7'h00;
         file_wdata <= 8'h00;
         irq_stat <= 3'h0;
         irq_en <= 3'h0;
         irq <= 1'b0;
      end else begin
         pend <= next_pend;
         pend_op <= next_pend_op;
         acc <= next_acc;
         fdata <= next_fdata;
         carry <= next_carry;
         nibf <= next_nibf;
         zf <= next_zf;
         expiry_flag <= next_expiry_flag;
         low_power_entry_flag <= next_low_power_entry_flag;
         sleeping <= next_sleeping;
         osc_en <= next_osc_en;
         presc <= next_presc;
         watchdog_counter <= next_watchdog_counter;
         file_we <= next_file_we;
         file_addr <= next_file_addr;
         file_wdata <= next_file_wdata;
         irq_stat <= next_irq_stat;
         irq_en <= next_irq_en;
         irq <= next_irq;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   property p_wdog_clr;
      kind == K_SLEEP |=> watchdog_counter == 8'h00 && presc == 8'h00;
   endproperty
   a_wdog_clr: assert property (p_wdog_clr) else $error("watchdog not cleared");
   property p_sleep_flags;
      kind == K_SLEEP |=> expiry_flag && !low_power_entry_flag
         && $stable(carry) && $stable(nibf) && $stable(zf);
   endproperty
   a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong");
   property p_osc_stop;
      kind == K_SLEEP |=> !osc_en && sleeping ##1 !osc_en;
   endproperty
   a_osc_stop: assert property (p_osc_stop) else $error("oscillator still running");
   property p_lit;
      kind == K_LIT |=> acc == 8'($past(pend_op[7:0]) - $past(acc)) && !file_we;
   endproperty
   a_lit: assert property (p_lit) else $error("literal subtract wrong");
   property p_file_acc;
      kind == K_FILE && !pend_op[7] |=> acc == 8'($past(fdata) - $past(acc)) && !file_we;
   endproperty
   a_file_acc: assert property (p_file_acc) else $error("file subtract to acc wrong");
   property p_file_wb;
      kind == K_FILE && pend_op[7] |=> file_we && $stable(acc)
         && file_addr == $past(pend_op[6:0]) && file_wdata == 8'($past(fdata) - $past(acc));
   endproperty
   a_file_wb: assert property (p_file_wb) else $error("file write back wrong");
   property p_carry;
      kind == K_LIT || kind == K_FILE |=> carry == ($past(sub_a) >= $past(acc));
   endproperty
   a_carry: assert property (p_carry) else $error("carry wrong");
   property p_zero_nib;
      kind == K_LIT || kind == K_FILE |=> zf == ($past(sub_a) == $past(acc))
         && nibf == ($past(sub_a[3:0]) >= $past(acc[3:0]));
   endproperty
   a_zero_nib: assert property (p_zero_nib) else $error("zero or nibble flag wrong");
endmodule : sse_exec

// ### logic/sse_params.svh
// constants for the subtract and sleep execution block
`ifndef SSE_PARAMS_SVH
`define SSE_PARAMS_SVH
`define SSE_A_OPC 8'h00
`define SSE_A_FDATA 8'h04
`define SSE_A_ACC 8'h08
`define SSE_A_STAT 8'h0C
`define SSE_A_WDOG 8'h10
`define SSE_A_IRQ_STAT 8'h14
`define SSE_A_IRQ_CLR 8'h18
`define SSE_A_IRQ_EN 8'h1C
`define SSE_A_WAKE 8'h20
`define SSE_OP_SLEEP 14'h0063
`define SSE_OP_LIT 5'h1E
`define SSE_OP_FILE 6'h02
`define SSE_B_CARRY 0
`define SSE_B_NIB 1
`define SSE_B_ZERO 2
`define SSE_B_LPE 3
`define SSE_B_EXP 4
`define SSE_B_SLP 5
`define SSE_EV_DONE 0
`define SSE_EV_SLEEP 1
`define SSE_EV_BAD 2
`define SSE_RST_EXP 1'b1
`define SSE_RST_LPE 1'b1
`define SSE_PRESC_MAX 8'hFF
`define SSE_WDOG_CLR 8'h00
`define SSE_RESP_OK 2'h0
`define SSE_RESP_ERR 2'h2
`endif

// ### logic/sse_pkg.sv
// types for the subtract and sleep execution block
package sse_pkg;
   typedef enum logic [2:0] {K_NONE, K_SLEEP, K_LIT, K_FILE, K_BAD} sse_kind_t;
   typedef logic [2:0] sse_ev_t;
endpackage : sse_pkg

// ### verif/tb.sv
// self-checking bench for the subtract and sleep execution block
`include "sse_params.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sse_pkg::*;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [31:0] s_axi_awaddr = 32'h0;
   logic s_axi_awvalid = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_bready = 1'b0;
   logic [31:0] s_axi_araddr = 32'h0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata, rd, st;
   logic [1:0] rs;
   sse_ev_t irq_stat;
   logic irq, osc_en, file_we;
   logic [6:0] file_addr, we_addr;
   logic [7:0] file_wdata, we_data;
   int miscompares = 0;
   int n_tests = 0;
   int we_cnt = 0;

   always #5 mclk = ~mclk;

   sse_exec i_sse_exec (.mclk(mclk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .irq_stat(irq_stat), .irq(irq), .osc_en(osc_en),
      .file_we(file_we), .file_addr(file_addr), .file_wdata(file_wdata));

   // pulse counter, sees the value held during the pulse cycle
   always @(posedge mclk) begin
      if (file_we === 1'b1) begin
         we_cnt <= we_cnt + 1;
         we_addr <= file_addr;
         we_data <= file_wdata;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // readies are flops, so the negedge view equals what the next edge samples
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_p, w_p, ta, tw;
      aw_p = 1'b1;
      w_p = 1'b1;
      @(posedge mclk);
      s_axi_awaddr <= {24'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (aw_p || w_p) begin
         @(negedge mclk);
         ta = aw_p && s_axi_awready === 1'b1;
         tw = w_p && s_axi_wready === 1'b1;
         @(posedge mclk);
         if (ta) begin
            aw_p = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (tw) begin
            w_p = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      do begin
         @(negedge mclk);
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      @(posedge mclk);
      s_axi_bready <= 1'b0;
      @(negedge mclk);
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge mclk);
      s_axi_araddr <= {24'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge mclk);
      end while (s_axi_arready !== 1'b1);
      @(posedge mclk);
      s_axi_arvalid <= 1'b0;
      do begin
         @(negedge mclk);
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk);
      s_axi_rready <= 1'b0;
      @(negedge mclk);
   endtask : axi_rd

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
      chk({30'h0, r}, {30'h0, `SSE_RESP_OK});
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      axi_rd(a, rd, rs);
      chk(rd, exp);
   endtask : rdchk

   task automatic t_unmapped;
      axi_wr(8'h40, 32'h1, rs);
      chk({30'h0, rs}, {30'h0, `SSE_RESP_ERR});
      axi_rd(8'h40, rd, rs);
      chk({rd[29:0], rs}, {30'h0, `SSE_RESP_ERR});
   endtask : t_unmapped

   // borrow edges: zero, negative, low nibble borrow, top literal
   task automatic t_lit;
      logic [7:0] k [5] = '{8'h02, 8'h02, 8'h02, 8'h10, 8'hFF};
      logic [7:0] a [5] = '{8'h01, 8'h02, 8'h03, 8'h01, 8'h00};
      logic [7:0] e;
      for (int i = 0; i < 5; i++) begin
         e = k[i] - a[i];
         wr(`SSE_A_ACC, {24'h0, a[i]});
         wr(`SSE_A_OPC, {18'h0, 5'h1E, i[0], k[i]});
         rdchk(`SSE_A_ACC, {24'h0, e});
         axi_rd(`SSE_A_STAT, rd, rs);
         chk({29'h0, rd[2:0]}, {29'h0, e == 8'h00, k[i][3:0] >= a[i][3:0], k[i] >= a[i]});
      end
   endtask : t_lit

   task automatic t_file;
      int n;
      wr(`SSE_A_FDATA, 32'h35);
      wr(`SSE_A_ACC, 32'h36);
      n = we_cnt;
      wr(`SSE_A_OPC, 32'h02D5);
      rdchk(`SSE_A_FDATA, 32'hFF);
      rdchk(`SSE_A_ACC, 32'h36);
      chk(we_cnt - n, 32'h1);
      chk({17'h0, we_addr, we_data}, 32'h55FF);
      rdchk(`SSE_A_STAT, 32'h18);
      wr(`SSE_A_FDATA, 32'h40);
      wr(`SSE_A_ACC, 32'h0F);
      n = we_cnt;
      wr(`SSE_A_OPC, 32'h0211);
      rdchk(`SSE_A_ACC, 32'h31);
      rdchk(`SSE_A_FDATA, 32'h40);
      chk(we_cnt - n, 32'h0);
      rdchk(`SSE_A_STAT, 32'h19);
   endtask : t_file

   task automatic t_bad;
      wr(`SSE_A_IRQ_EN, 32'h4);
      wr(`SSE_A_OPC, 32'h3FFF);
      chk({28'h0, irq_stat[2], 2'h0, irq}, 32'h9);
      wr(`SSE_A_IRQ_EN, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(`SSE_A_IRQ_CLR, 32'h7);
      chk({29'h0, irq_stat}, 32'h0);
   endtask : t_bad

   // leftover flags must survive the sleep entry untouched
   task automatic t_sleep;
      axi_rd(`SSE_A_STAT, st, rs);
      wr(`SSE_A_IRQ_EN, 32'h2);
      wr(`SSE_A_OPC, {18'h0, `SSE_OP_SLEEP});
      rdchk(`SSE_A_STAT, {26'h0, 3'b110, st[2:0]});
      chk({31'h0, osc_en}, 32'h0);
      axi_rd(`SSE_A_WDOG, rd, rs);
      chk({24'h0, rd[7:0]}, 32'h0);
      chk({31'h0, rd[15:8] < 8'h20}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wr(`SSE_A_OPC, 32'h3C00);
      rdchk(`SSE_A_STAT, {26'h0, 3'b110, st[2:0]});
      wr(`SSE_A_WAKE, 32'h1);
      chk({31'h0, osc_en}, 32'h1);
      wr(`SSE_A_IRQ_CLR, 32'h7);
      chk({28'h0, irq_stat, irq}, 32'h0);
   endtask : t_sleep

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (12) @(posedge mclk);
      sys_rst <= 1'b0;
      rdchk(`SSE_A_STAT, 32'h18);
      chk({31'h0, osc_en}, 32'h1);
      t_unmapped;
      t_lit;
      t_file;
      t_bad;
      t_sleep;
      report_and_stop;
   end

   // whole run needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge mclk);
      miscompares++;
      report_and_stop;
   end
endmodule : tb
